//--- logic/psr_shift_register.sv
// Module: four-stage parallel-access shift register
`timescale 1ns/1ps
// Behaviour
// - Four stages, each with data in/out
// - Clear low forces stages low, complement high
// - Control low loads parallel data
// - Apart from clear, stages change only on rising clock
// - Serial inputs ignored during load
// - Control high shifts each rising edge
// - Each later stage takes previous stage
// - First stage follows J and inverted-K table
// - No edge with clear high means every stage holds
// - Last stage given true and complemented
module psr_shift_register (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear_n,
  input wire logic shift_not_parallel_capture,
  input wire logic serial_j,
  input wire logic serial_k_n,
  input wire logic [psr_pkg::PSR_STAGES-1:0] parallel_data,
  output logic first_stage_out,
  output logic second_stage_out,
  output logic third_stage_out,
  output logic last_stage_out,
  output logic last_stage_out_n
);
  import psr_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  wire logic [PSR_STAGES-1:0] stage;
  wire logic [PSR_STAGES-1:0] next_stage;
  logic next_last_n;
  psr_mode_e mode;
  psr_first_if fi ();

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  // Clear is kept out of the mode: it must act without a clock edge, so it
  // sits on the asynchronous path of every register instead.
  always_comb begin
    case (shift_not_parallel_capture)
      1'h0: begin
        mode = PSR_LOAD;
      end
      1'h1: begin
        mode = PSR_SHIFT;
      end
      default: begin
        mode = PSR_HOLD;
      end
    endcase
  end

  // ----------------------------------------
  // First-stage serial logic
  // ----------------------------------------
  assign fi.serial_j = serial_j;
  assign fi.serial_k_n = serial_k_n;
  assign fi.current = stage[0];

  psr_first_stage u_first (
    .fi(fi.stage)
  );

  // ----------------------------------------
  // Stages
  // ----------------------------------------
  for (genvar i = 0; i < PSR_STAGES; i++) begin : g_stage
    logic shift_src;
    logic next_bit;
    logic bit_q;

    if (i == 0) begin : g_head
      assign shift_src = fi.next_first;
    end else begin : g_tail
      assign shift_src = stage[i-1];
    end

    always_comb begin
      case (mode)
        PSR_LOAD: begin
          next_bit = parallel_data[i];
        end
        PSR_SHIFT: begin
          next_bit = shift_src;
        end
        default: begin
          next_bit = bit_q;
        end
      endcase
    end

    // Reset waits for the edge like every reset here; clear may not wait
    always_ff @(posedge clk or negedge clear_n) begin
      if (!clear_n) begin
        bit_q <= PSR_RESET_STAGES[i];
      end else if (!reset_n) begin
        bit_q <= PSR_RESET_STAGES[i];
      end else begin
        bit_q <= next_bit;
      end
    end

    assign stage[i] = bit_q;
    assign next_stage[i] = next_bit;
  end

  // ----------------------------------------
  // Complemented last stage
  // ----------------------------------------
  // Own flip-flop so the pin is registered, fed from the last stage's next
  // value so the pair cannot drift apart.
  assign next_last_n = ~next_stage[PSR_STAGES-1];

  always_ff @(posedge clk or negedge clear_n) begin
    if (!clear_n) begin
      last_stage_out_n <= PSR_RESET_LAST_N;
    end else if (!reset_n) begin
      last_stage_out_n <= PSR_RESET_LAST_N;
    end else begin
      last_stage_out_n <= next_last_n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign first_stage_out = stage[0];
  assign second_stage_out = stage[1];
  assign third_stage_out = stage[2];
  assign last_stage_out = stage[PSR_STAGES-1];
endmodule // psr_shift_register

//--- logic/psr_pkg.sv
// Package: constants for the four-stage parallel-access shift register
package psr_pkg;
  localparam int PSR_STAGES = 4;
  localparam logic [3:0] PSR_RESET_STAGES = 4'h0;
  localparam logic PSR_RESET_LAST_N = 1'h1;
  typedef enum logic [1:0] {
    PSR_HOLD = 2'h0,
    PSR_LOAD = 2'h1,
    PSR_SHIFT = 2'h3
  } psr_mode_e;
endpackage

//--- logic/psr_first_if.sv
// Interface: serial first-stage inputs and current value toward the first-stage logic
`timescale 1ns/1ps
interface psr_first_if;
  logic serial_j;
  logic serial_k_n;
  logic current;
  logic next_first;
  modport core (output serial_j, output serial_k_n, output current, input next_first);
  modport stage (input serial_j, input serial_k_n, input current, output next_first);
endinterface

//--- logic/psr_first_stage.sv
// Module: next value of the first stage from the two serial inputs
`timescale 1ns/1ps
module psr_first_stage (
  psr_first_if.stage fi
);
  import psr_pkg::*;
  // J with active-low K: D-type when tied, T-type when opposite
  always_comb begin
    case ({fi.serial_j, fi.serial_k_n})
      2'h0: fi.next_first = 1'h0;
      2'h1: fi.next_first = fi.current;
      2'h2: fi.next_first = ~fi.current;
      2'h3: fi.next_first = 1'h1;
      default: fi.next_first = 1'h0;
    endcase
  end
endmodule // psr_first_stage

//--- verif/psr_props.sv
// Checker on the shift register ports
`timescale 1ns/1ps
module psr_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear_n,
  input wire logic shift_not_parallel_capture,
  input wire logic serial_j,
  input wire logic serial_k_n,
  input wire logic [3:0] parallel_data,
  input wire logic first_stage_out,
  input wire logic second_stage_out,
  input wire logic third_stage_out,
  input wire logic last_stage_out,
  input wire logic last_stage_out_n
);
  wire s = clear_n && shift_not_parallel_capture;
  wire ld = clear_n && !shift_not_parallel_capture;
  wire [3:0] q = {last_stage_out, third_stage_out, second_stage_out, first_stage_out};
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Clear may fall at any falling edge, so one-cycle checks need it high at both ends
  clear_low_a: assert property (!clear_n |-> q == 4'h0 && last_stage_out_n)
    else $error("outputs not in clear state while clear is low");
  load_cap_a: assert property (ld ##1 clear_n |-> q == $past(parallel_data))
    else $error("stages differ from loaded data");
  load_comp_a: assert property (ld ##1 clear_n |->
    last_stage_out_n != $past(parallel_data[3]))
    else $error("complement wrong after load");
  shift_mv_a: assert property (s ##1 clear_n |-> q[3:1] == $past(q[2:0]))
    else $error("stages did not move by one place");
  first_jk_a: assert property (s ##1 clear_n |->
    first_stage_out == ($past(serial_j) ? ($past(serial_k_n) || !$past(first_stage_out))
    : ($past(serial_k_n) && $past(first_stage_out))))
    else $error("first stage serial entry wrong");
  out_inv_a: assert property (last_stage_out_n != last_stage_out)
    else $error("last stage outputs not opposite");
  cover property (s);
  cover property (!clear_n);
  cover property (ld);
  cover property (s && serial_j && !serial_k_n);
endmodule // psr_props
bind psr_shift_register psr_props props (
  .clk(clk),
  .reset_n(reset_n),
  .clear_n(clear_n),
  .shift_not_parallel_capture(shift_not_parallel_capture),
  .serial_j(serial_j),
  .serial_k_n(serial_k_n),
  .parallel_data(parallel_data),
  .first_stage_out(first_stage_out),
  .second_stage_out(second_stage_out),
  .third_stage_out(third_stage_out),
  .last_stage_out(last_stage_out),
  .last_stage_out_n(last_stage_out_n)
);

//--- verif/psr_host.sv
// Host model: random control and data
`timescale 1ns/1ps
module psr_host (
  input wire logic clk,
  output logic [7:0] v
);
  integer seed = 32'h6845;
  initial v = 8'h00;
  // Clear kept rare so shift runs grow long
  always @(negedge clk) v <= {($random(seed) & 7) != 0, 7'($random(seed))};
endmodule // psr_host

//--- verif/psr_shift_register_tb.sv
// Bench: random traffic against a reference model
`timescale 1ns/1ps
module psr_shift_register_tb;
  logic clk = 0, reset_n = 0, mn;
  logic [7:0] v;
  logic [3:0] q, m = 4'h0;
  integer fails = 0, cmp_count = 0;
  psr_host host (.clk(clk), .v(v));
  psr_shift_register dut (.clk(clk), .reset_n(reset_n), .clear_n(v[7]),
    .shift_not_parallel_capture(v[6]), .serial_j(v[5]), .serial_k_n(v[4]),
    .parallel_data(v[3:0]), .first_stage_out(q[0]), .second_stage_out(q[1]),
    .third_stage_out(q[2]), .last_stage_out(q[3]), .last_stage_out_n(mn));
  initial forever #4 clk = ~clk;
  always @(posedge clk) m <= !reset_n || !v[7] ? 4'h0 : !v[6] ? v[3:0]
    : {m[2:0], v[5] ? v[4] | ~m[0] : v[4] & m[0]};
  task chk(input logic [4:0] g, e);
    cmp_count++;
    if (g !== e) fails++;
    if (g !== e) $display("ERROR %0t %h %h", $time, g, e);
  endtask
  task close_out;
    $display("counts %0d %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #20000 fails++;
    close_out;
  end
  // Clear acts without the clock, so it is also checked just after it falls
  task run(input int n);
    repeat (n) begin
      @(negedge clk);
      chk({mn, q}, {~m[3], m});
      #1;
      if (!v[7]) chk({mn, q}, 5'h10);
    end
  endtask
  initial begin
    repeat (12) @(negedge clk);
    reset_n = 1;
    run(1500);
    $display("random test done");
    @(negedge clk) reset_n = 0;
    run(3);
    @(negedge clk) reset_n = 1;
    run(500);
    $display("mid-run reset test done");
    close_out;
  end
endmodule // psr_shift_register_tb
